// *** hdl/adcsq_pkg.sv ***
`default_nettype none
package adcsq_pkg;
    // Register offsets on the plain register port
    localparam logic [3:0] ADCSQ_OFS_CTRL_A   = 4'h0;
    localparam logic [3:0] ADCSQ_OFS_CTRL_B   = 4'h1;
    localparam logic [3:0] ADCSQ_OFS_PIN_EN   = 4'h2;
    localparam logic [3:0] ADCSQ_OFS_RES_LO   = 4'h3;
    localparam logic [3:0] ADCSQ_OFS_RES_HI   = 4'h4;
    localparam logic [3:0] ADCSQ_OFS_IRQ_CTRL = 4'h5;
    localparam logic [3:0] ADCSQ_OFS_IRQ_STAT = 4'h6;
    localparam logic [3:0] ADCSQ_OFS_IRQ_MASK = 4'h7;

    // Control A fields
    localparam int ADCSQ_A_CHLO_LSB  = 0;
    localparam int ADCSQ_A_PWRDN_BIT = 5;
    localparam int ADCSQ_A_DONEN_BIT = 6;
    localparam int ADCSQ_A_START_BIT = 7;
    // Control B fields
    localparam int ADCSQ_B_DIV_LSB   = 0;
    localparam int ADCSQ_B_REF_BIT   = 3;
    localparam int ADCSQ_B_CHHI_BIT  = 7;
    // Interrupt control fields
    localparam int ADCSQ_I_GLB_BIT   = 0;
    localparam int ADCSQ_I_CONV_BIT  = 1;
    localparam int ADCSQ_I_REQ_BIT   = 2;
    // Status / mask bits
    localparam int ADCSQ_S_DONE_BIT  = 0;
    localparam int ADCSQ_S_START_BIT = 1;

    // Reset values
    localparam logic [7:0] ADCSQ_RST_CTRL_A = 8'h60;
    localparam logic [7:0] ADCSQ_RST_CTRL_B = 8'h00;
    localparam logic [7:0] ADCSQ_RST_PIN_EN = 8'h00;
    localparam logic [7:0] ADCSQ_RST_MASK   = 8'h00;

    // Conversion length in converter clock periods
    localparam int ADCSQ_CONV_PERIODS = 16;
    localparam int ADCSQ_RES_W        = 12;
    localparam logic [2:0] ADCSQ_DIV_UNDEF = 3'h7;

    typedef enum logic [1:0] {
        ADCSQ_IDLE  = 2'b00,
        ADCSQ_ARMED = 2'b01,
        ADCSQ_CONV  = 2'b11
    } adcsq_state_t;
endpackage
`default_nettype wire

// *** hdl/adcsq_clkdiv.sv ***
`default_nettype none
module adcsq_clkdiv
    import adcsq_pkg::*;
(
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       arst_n_i,
    // Control
    input  wire logic       run_i,
    input  wire logic [2:0] sel_i,
    // Converter clock enable
    output logic            tick_o
);
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;
    logic       tick_nxt;
    logic [5:0] last;

    // RQ2: divider code map
    always_comb begin
        last = 6'h00;
        case (sel_i)
            3'h0:    last = 6'h00;
            3'h1:    last = 6'h01;
            3'h2:    last = 6'h03;
            3'h3:    last = 6'h07;
            3'h4:    last = 6'h0F;
            3'h5:    last = 6'h1F;
            3'h6:    last = 6'h3F;
            default: last = 6'h3F; // Undefined code runs at slowest rate
        endcase
    end

    // RQ1: converter clock enable
    always_comb begin
        cnt_nxt  = cnt_r + 6'h01;
        tick_nxt = 1'b0;
        if (!run_i) begin
            cnt_nxt = 6'h00;
        end else if (cnt_r >= last) begin
            cnt_nxt  = 6'h00;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_r  <= 6'h00;
            tick_o <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            tick_o <= tick_nxt;
        end
    end
endmodule
`default_nettype wire

// *** hdl/adcsq_sar.sv ***
`default_nettype none
module adcsq_sar
    import adcsq_pkg::*;
#(
    parameter int RES_W = 12
)(
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             arst_n_i,
    // Control
    input  wire logic             clear_i,
    input  wire logic             load_i,
    input  wire logic             step_i,
    // Comparator result from the analog front end
    input  wire logic             cmp_i,
    // Approximation
    output logic [RES_W-1:0]      trial_o,
    output logic [RES_W-1:0]      value_o
);
    logic [RES_W-1:0] trial_r, trial_nxt;
    logic [RES_W-1:0] bit_r, bit_nxt;
    logic [RES_W-1:0] keep;

    // RQ14: binary weights, MSB first
    always_comb begin
        trial_nxt = trial_r;
        bit_nxt   = bit_r;
        keep      = cmp_i ? trial_r : (trial_r & ~bit_r);
        if (clear_i) begin
            trial_nxt = '0;
            bit_nxt   = '0;
        end else if (load_i) begin
            bit_nxt   = {1'b1, {(RES_W-1){1'b0}}};
            trial_nxt = {1'b1, {(RES_W-1){1'b0}}};
        end else if (step_i && bit_r != '0) begin
            bit_nxt   = bit_r >> 1;
            trial_nxt = keep | (bit_r >> 1);
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            trial_r <= '0;
            bit_r   <= '0;
        end else begin
            trial_r <= trial_nxt;
            bit_r   <= bit_nxt;
        end
    end

    // Next trial, so the registered code is current at each tick
    assign trial_o = trial_nxt;
    assign value_o = keep;
endmodule
`default_nettype wire

// *** hdl/adcsq_top.sv ***
// Design decisions made here: the address map and the address-and-strobe port.
`default_nettype none
// Overview of operation
// RQ1: Converter clock comes from system clock via 3-bit divider select.
// RQ2: Codes 0..6 give divide by 1,2,4,...,64; code 7 undefined.
// RQ3: Power-down bit low powers converter; high switches it off.
// RQ4: Channel select is one high bit in B plus three low in A.
// RQ5: Eight pin enable bits choose which port pins are analog inputs.
// RQ6: Enabled pin: analog, other functions off, direction overridden, no pull.
// RQ7: Interrupt only with global and converter enables both high; code also raises irq_o from masked status bits.
// RQ8: Software pulses start low-high-low from an initial zero.
// RQ9: Start rising edge resets converter; falling edge begins conversion.
// RQ10: Done flag falls at completion with new result in result registers.
// RQ11: Completion clears done flag and sets the interrupt request flag.
// RQ12: Conversion takes sixteen converter clock periods.
// RQ13: Result is 12-bit unsigned, full scale FFF.
// RQ14: One code step equals reference voltage over 4096.
// RQ15: Software reads low result byte then high byte.
// RQ16: Interrupt users keep interrupts enabled and stack not full.
// RQ17: Conversion runs on its own; processor never stalls.
// RQ18: Polling software may leave converter interrupt disabled.
// RQ19: Result registers stay stable until the next conversion completes.
module adcsq_top
    import adcsq_pkg::*;
#(
    parameter int PINS  = 8,
    parameter int RES_W = ADCSQ_RES_W
)(
    // Clock and reset
    input  wire logic            clock_i,
    input  wire logic            arst_n_i,
    // Register port
    input  wire logic [3:0]      reg_addr_i,
    input  wire logic [7:0]      reg_wdata_i,
    input  wire logic            reg_wr_i,
    input  wire logic            reg_rd_i,
    output logic      [7:0]      reg_rdata_o,
    // Analog front end
    input  wire logic            cmp_i,
    output logic [RES_W-1:0]     dac_code_o,
    output logic                 conv_power_down_o,
    output logic                 afe_reset_o,
    output logic      [3:0]      chan_sel_o,
    output logic                 reference_select_o,
    // Port pin control
    output logic [PINS-1:0]      analog_pin_enable_o,
    output logic [PINS-1:0]      pin_func_off_o,
    output logic [PINS-1:0]      pin_dir_override_o,
    output logic [PINS-1:0]      pin_pull_off_o,
    // Interrupt
    output logic                 irq_o
);
    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic [7:0]          conv_control_a_r, conv_control_a_nxt;
    logic [7:0]          conv_control_b_r, conv_control_b_nxt;
    logic [PINS-1:0]     analog_pin_enable_reg_r, analog_pin_enable_reg_nxt;
    logic                global_irq_enable_r, global_irq_enable_nxt;
    logic                conv_irq_enable_r, conv_irq_enable_nxt;
    logic                irq_req_r, irq_req_nxt;
    logic [1:0]          stat_r, stat_nxt;
    logic [1:0]          mask_r, mask_nxt;
    logic [RES_W-1:0]    result_r, result_nxt;
    logic [7:0]          rdata_nxt;
    logic                irq_nxt;

    // Sequencer state
    adcsq_state_t        state_r, state_nxt;
    logic [4:0]          per_r, per_nxt;
    logic                start_q_r;
    logic                tick;
    logic                sar_clear, sar_load, sar_step;
    logic [RES_W-1:0]    trial, final_val;
    logic                done_ev, start_ev;

    logic                wr_a, start_bit, power_down;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction

    assign wr_a       = reg_wr_i && hit(reg_addr_i, ADCSQ_OFS_CTRL_A);
    assign start_bit  = conv_control_a_r[ADCSQ_A_START_BIT];
    // RQ3: power-down control
    assign power_down = conv_control_a_r[ADCSQ_A_PWRDN_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Converter clock divider
    // RQ1: divider runs only during a conversion
    adcsq_clkdiv u_div (
        .clock_i  (clock_i),
        .arst_n_i (arst_n_i),
        .run_i    (state_r == ADCSQ_CONV),
        .sel_i    (conv_control_b_r[ADCSQ_B_DIV_LSB +: 3]),
        .tick_o   (tick)
    );

    // Successive approximation register
    adcsq_sar #(.RES_W(RES_W)) u_sar (
        .clock_i  (clock_i),
        .arst_n_i (arst_n_i),
        .clear_i  (sar_clear),
        .load_i   (sar_load),
        .step_i   (sar_step),
        .cmp_i    (cmp_i),
        .trial_o  (trial),
        .value_o  (final_val)
    );

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequencer
    // Periods 0..3 settle/sample, 4..15 resolve the twelve bits
    always_comb begin
        state_nxt = state_r;
        per_nxt   = per_r;
        sar_clear = 1'b0;
        sar_load  = 1'b0;
        sar_step  = 1'b0;
        done_ev   = 1'b0;
        start_ev  = 1'b0;
        unique case (state_r)
            ADCSQ_IDLE: begin
                // RQ9: rising start edge resets
                if (start_bit && !start_q_r && !power_down) begin
                    state_nxt = ADCSQ_ARMED;
                    sar_clear = 1'b1;
                end
            end
            ADCSQ_ARMED: begin
                // RQ9: falling start edge begins
                if (power_down) begin
                    state_nxt = ADCSQ_IDLE;
                end else if (!start_bit) begin
                    state_nxt = ADCSQ_CONV;
                    per_nxt   = 5'h00;
                    start_ev  = 1'b1;
                end
            end
            ADCSQ_CONV: begin
                if (power_down) begin
                    state_nxt = ADCSQ_IDLE;
                end else if (start_bit && !start_q_r) begin
                    // New rising edge aborts and re-arms
                    state_nxt = ADCSQ_ARMED;
                    sar_clear = 1'b1;
                end else if (tick) begin
                    // RQ12: sixteen converter periods
                    per_nxt = per_r + 5'h01;
                    if (per_r == 5'(ADCSQ_CONV_PERIODS - RES_W - 1)) begin
                        sar_load = 1'b1;
                    end else if (per_r >= 5'(ADCSQ_CONV_PERIODS - RES_W)) begin
                        sar_step = 1'b1;
                    end
                    if (per_r == 5'(ADCSQ_CONV_PERIODS - 1)) begin
                        state_nxt = ADCSQ_IDLE;
                        done_ev   = 1'b1;
                    end
                end
            end
            default: state_nxt = ADCSQ_IDLE;
        endcase
    end

    // RQ17: sequencer runs without stalling the register port
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r   <= ADCSQ_IDLE;
            per_r     <= 5'h00;
            start_q_r <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            per_r     <= per_nxt;
            start_q_r <= start_bit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes and hardware updates
    always_comb begin
        conv_control_a_nxt        = conv_control_a_r;
        conv_control_b_nxt        = conv_control_b_r;
        analog_pin_enable_reg_nxt = analog_pin_enable_reg_r;
        global_irq_enable_nxt     = global_irq_enable_r;
        conv_irq_enable_nxt       = conv_irq_enable_r;
        irq_req_nxt               = irq_req_r;
        stat_nxt                  = stat_r;
        mask_nxt                  = mask_r;
        result_nxt                = result_r;
        if (wr_a) begin
            // Done flag is read-only to software
            conv_control_a_nxt = {reg_wdata_i[7], conv_control_a_r[6],
                                  reg_wdata_i[5:0]};
        end
        if (reg_wr_i && hit(reg_addr_i, ADCSQ_OFS_CTRL_B)) begin
            conv_control_b_nxt = reg_wdata_i;
        end
        // RQ5: pin enable register
        if (reg_wr_i && hit(reg_addr_i, ADCSQ_OFS_PIN_EN)) begin
            analog_pin_enable_reg_nxt = reg_wdata_i[PINS-1:0];
        end
        if (reg_wr_i && hit(reg_addr_i, ADCSQ_OFS_IRQ_CTRL)) begin
            global_irq_enable_nxt = reg_wdata_i[ADCSQ_I_GLB_BIT];
            conv_irq_enable_nxt   = reg_wdata_i[ADCSQ_I_CONV_BIT];
            irq_req_nxt           = reg_wdata_i[ADCSQ_I_REQ_BIT];
        end
        if (reg_wr_i && hit(reg_addr_i, ADCSQ_OFS_IRQ_MASK)) begin
            mask_nxt = reg_wdata_i[1:0];
        end
        // Read of status clears it; a same-cycle event wins
        if (reg_rd_i && hit(reg_addr_i, ADCSQ_OFS_IRQ_STAT)) begin
            stat_nxt = 2'b00;
        end
        if (start_ev) begin
            stat_nxt[ADCSQ_S_START_BIT] = 1'b1;
            conv_control_a_nxt[ADCSQ_A_DONEN_BIT] = 1'b1;
        end
        if (sar_clear) begin
            conv_control_a_nxt[ADCSQ_A_DONEN_BIT] = 1'b1;
        end
        if (done_ev) begin
            // RQ10: done flag falls with new result
            conv_control_a_nxt[ADCSQ_A_DONEN_BIT] = 1'b0;
            // RQ13: twelve-bit unsigned result
            result_nxt = final_val;
            // RQ11: request flag set, wins over clear
            irq_req_nxt = 1'b1;
            stat_nxt[ADCSQ_S_DONE_BIT] = 1'b1;
        end
    end

    // RQ19: result changes only on completion
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            conv_control_a_r        <= ADCSQ_RST_CTRL_A;
            conv_control_b_r        <= ADCSQ_RST_CTRL_B;
            analog_pin_enable_reg_r <= ADCSQ_RST_PIN_EN[PINS-1:0];
            global_irq_enable_r     <= 1'b0;
            conv_irq_enable_r       <= 1'b0;
            irq_req_r               <= 1'b0;
            stat_r                  <= 2'b00;
            mask_r                  <= ADCSQ_RST_MASK[1:0];
            result_r                <= '0;
        end else begin
            conv_control_a_r        <= conv_control_a_nxt;
            conv_control_b_r        <= conv_control_b_nxt;
            analog_pin_enable_reg_r <= analog_pin_enable_reg_nxt;
            global_irq_enable_r     <= global_irq_enable_nxt;
            conv_irq_enable_r       <= conv_irq_enable_nxt;
            irq_req_r               <= irq_req_nxt;
            stat_r                  <= stat_nxt;
            mask_r                  <= mask_nxt;
            result_r                <= result_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux, registered for the next cycle
    always_comb begin
        rdata_nxt = 8'h00;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                ADCSQ_OFS_CTRL_A:   rdata_nxt = conv_control_a_r;
                ADCSQ_OFS_CTRL_B:   rdata_nxt = conv_control_b_r;
                ADCSQ_OFS_PIN_EN:   rdata_nxt = 8'(analog_pin_enable_reg_r);
                // RQ15: low byte then high byte
                ADCSQ_OFS_RES_LO:   rdata_nxt = result_r[7:0];
                ADCSQ_OFS_RES_HI:   rdata_nxt = 8'(result_r[RES_W-1:8]);
                ADCSQ_OFS_IRQ_CTRL: rdata_nxt = {5'h00, irq_req_r,
                                    conv_irq_enable_r, global_irq_enable_r};
                ADCSQ_OFS_IRQ_STAT: rdata_nxt = {6'h00, stat_r};
                ADCSQ_OFS_IRQ_MASK: rdata_nxt = {6'h00, mask_r};
                default:            rdata_nxt = 8'h00;
            endcase
        end
    end

    // RQ7: both enables gate the request; mask gates status
    assign irq_nxt = (irq_req_nxt && global_irq_enable_nxt
                      && conv_irq_enable_nxt) || |(stat_nxt & mask_nxt);

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o         <= 8'h00;
            irq_o               <= 1'b0;
            dac_code_o          <= '0;
            conv_power_down_o   <= 1'b1;
            afe_reset_o         <= 1'b0;
            chan_sel_o          <= 4'h0;
            reference_select_o  <= 1'b0;
            analog_pin_enable_o <= '0;
            pin_func_off_o      <= '0;
            pin_dir_override_o  <= '0;
            pin_pull_off_o      <= '0;
        end else begin
            reg_rdata_o         <= rdata_nxt;
            irq_o               <= irq_nxt;
            dac_code_o          <= trial;
            // RQ3: front end unpowered while bit high
            conv_power_down_o   <= conv_control_a_nxt[ADCSQ_A_PWRDN_BIT];
            afe_reset_o         <= state_nxt == ADCSQ_ARMED;
            // RQ4: split channel field
            chan_sel_o <= {conv_control_b_nxt[ADCSQ_B_CHHI_BIT],
                           conv_control_a_nxt[ADCSQ_A_CHLO_LSB +: 3]};
            reference_select_o  <= conv_control_b_nxt[ADCSQ_B_REF_BIT];
            // RQ6: analog pin overrides
            analog_pin_enable_o <= analog_pin_enable_reg_nxt;
            pin_func_off_o      <= analog_pin_enable_reg_nxt;
            pin_dir_override_o  <= analog_pin_enable_reg_nxt;
            pin_pull_off_o      <= analog_pin_enable_reg_nxt;
        end
    end
endmodule
`default_nettype wire

// *** test/adcsq_top_props.sv ***
`default_nettype none
module adcsq_top_props
    import adcsq_pkg::*;
#(
    parameter int PINS  = 8,
    parameter int RES_W = ADCSQ_RES_W
)(
    // Clock and reset
    input  wire logic            clock_i,
    input  wire logic            arst_n_i,
    // Register port
    input  wire logic [3:0]      reg_addr_i,
    input  wire logic [7:0]      reg_wdata_i,
    input  wire logic            reg_wr_i,
    input  wire logic            reg_rd_i,
    input  wire logic [7:0]      reg_rdata_o,
    // Converter and pin control
    input  wire logic            conv_power_down_o,
    input  wire logic            afe_reset_o,
    input  wire logic [3:0]      chan_sel_o,
    input  wire logic [PINS-1:0] analog_pin_enable_o,
    input  wire logic [PINS-1:0] pin_func_off_o,
    input  wire logic [PINS-1:0] pin_dir_override_o,
    input  wire logic [PINS-1:0] pin_pull_off_o,
    // Interrupt
    input  wire logic            irq_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!arst_n_i);

    ////////////////////////////////////////////////////////////////////////
    // Shadow of the enables, so a fully gated block can be held quiet
    logic [1:0] ien_r;
    logic [1:0] ien_nxt;
    logic [1:0] msk_r;
    logic [1:0] msk_nxt;
    wire logic  quiet = (ien_r != 2'h3) && (msk_r == 2'h0);

    // Next values of the shadow
    always_comb begin
        ien_nxt = ien_r;
        msk_nxt = msk_r;
        if (reg_wr_i && reg_addr_i == ADCSQ_OFS_IRQ_CTRL) begin
            ien_nxt = reg_wdata_i[1:0];
        end
        if (reg_wr_i && reg_addr_i == ADCSQ_OFS_IRQ_MASK) begin
            msk_nxt = reg_wdata_i[1:0];
        end
    end

    // Shadow registers
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ien_r <= 2'h0;
            msk_r <= 2'h0;
        end else begin
            ien_r <= ien_nxt;
            msk_r <= msk_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_pins_agree: assert property (
        analog_pin_enable_o == pin_func_off_o &&
        pin_func_off_o == pin_dir_override_o &&
        pin_dir_override_o == pin_pull_off_o)
        else $error("pin control outputs disagree");
    a_rdata_quiet: assert property (
        !$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside its cycle");
    a_pin_write: assert property (
        reg_wr_i && reg_addr_i == ADCSQ_OFS_PIN_EN
        |=> analog_pin_enable_o == $past(reg_wdata_i))
        else $error("pin enable write not applied");
    a_chan_low: assert property (
        reg_wr_i && reg_addr_i == ADCSQ_OFS_CTRL_A
        |=> chan_sel_o[2:0] == $past(reg_wdata_i[2:0]))
        else $error("low channel bits not applied");
    a_chan_high: assert property (
        reg_wr_i && reg_addr_i == ADCSQ_OFS_CTRL_B
        |=> chan_sel_o[3] == $past(reg_wdata_i[7]))
        else $error("high channel bit not applied");
    a_power_write: assert property (
        reg_wr_i && reg_addr_i == ADCSQ_OFS_CTRL_A
        |=> conv_power_down_o == $past(reg_wdata_i[5]))
        else $error("power down bit not applied");
    a_irq_gated: assert property (
        quiet [*2] |-> !irq_o)
        else $error("interrupt while disabled");
    a_arm_reset: assert property (
        reg_wr_i && reg_addr_i == ADCSQ_OFS_CTRL_A &&
        reg_wdata_i[7] && !reg_wdata_i[5] |-> ##2 afe_reset_o)
        else $error("start rise did not reset converter");
    a_arm_release: assert property (
        afe_reset_o && reg_wr_i && reg_addr_i == ADCSQ_OFS_CTRL_A &&
        !reg_wdata_i[7] |-> ##2 !afe_reset_o)
        else $error("start fall did not release converter");

    // Main scenarios
    c_start: cover property (reg_wr_i && reg_wdata_i[7] &&
        reg_addr_i == ADCSQ_OFS_CTRL_A);
    c_irq: cover property ($rose(irq_o));
    c_release: cover property ($fell(afe_reset_o));
endmodule

bind adcsq_top adcsq_top_props #(.PINS(PINS), .RES_W(RES_W)) u_props (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .conv_power_down_o(conv_power_down_o),
    .afe_reset_o(afe_reset_o), .chan_sel_o(chan_sel_o),
    .analog_pin_enable_o(analog_pin_enable_o),
    .pin_func_off_o(pin_func_off_o),
    .pin_dir_override_o(pin_dir_override_o),
    .pin_pull_off_o(pin_pull_off_o), .irq_o(irq_o));
`default_nettype wire

// *** test/adcsq_top_tb.sv ***
`default_nettype none
`define CHK(g, e) \
    begin \
        check_count++; \
        if ((g) !== (e)) begin \
            n_errors++; \
            $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); \
        end \
    end
module adcsq_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import adcsq_pkg::*;

    logic        clock_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic [3:0]  reg_addr_i = 4'h0;
    logic [7:0]  reg_wdata_i = 8'h00;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [7:0]  reg_rdata_o;
    logic [11:0] dac_code_o;
    logic [11:0] vin = 12'h000;
    logic [3:0]  chan_sel_o;
    logic [7:0]  pen, pfo, pdo, ppo;
    logic        pd, afe, ref_o, irq_o;
    logic [7:0]  rv, hi, b;
    logic [11:0] exp_q[$];
    wire logic   cmp_i = (vin >= dac_code_o);
    integer      seed = 65;
    integer      n_errors = 0;
    integer      check_count = 0;

    always #5 clock_i = ~clock_i;

    adcsq_top DUT (
        .clock_i(clock_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .cmp_i(cmp_i),
        .dac_code_o(dac_code_o), .conv_power_down_o(pd),
        .afe_reset_o(afe), .chan_sel_o(chan_sel_o),
        .reference_select_o(ref_o), .analog_pin_enable_o(pen),
        .pin_func_off_o(pfo), .pin_dir_override_o(pdo),
        .pin_pull_off_o(ppo), .irq_o(irq_o));

    ////////////////////////////////////////////////////////////////////////
    // Register port cycles, strobes one cycle wide
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        #1 rv = reg_rdata_o;
    endtask

    // One conversion; irq wait is timed, polling only bounded
    task automatic conv(input int sel, input bit use_irq);
        int   p, n, t0;
        logic [2:0] lo;
        p = 1 << ((sel == 7) ? 6 : sel);
        vin = 12'($random(seed));
        b = 8'($random(seed)) & 8'h88 | 8'(sel);
        lo = 3'($random(seed));
        wr(ADCSQ_OFS_CTRL_B, b);
        wr(ADCSQ_OFS_CTRL_A, {5'h10, lo});
        wr(ADCSQ_OFS_CTRL_A, {5'h00, lo});
        t0 = $time;
        exp_q.push_back(vin);
        if (sel >= 3 && exp_q.size() > 1) begin
            rd(ADCSQ_OFS_RES_LO);
            `CHK(rv, exp_q[0][7:0])
            rd(ADCSQ_OFS_CTRL_A);
            `CHK(rv[6], 1'b1)
        end
        if (exp_q.size() > 1) begin
            void'(exp_q.pop_front());
        end
        n = 0;
        rv = 8'h40;
        while ((use_irq ? !irq_o : rv[6] === 1'b1) && n < 3000) begin
            if (use_irq) begin
                @(posedge clock_i);
                #1;
            end else begin
                rd(ADCSQ_OFS_CTRL_A);
            end
            n++;
        end
        n = ($time - 1 - t0) / 10;
        if (use_irq) begin
            `CHK(n >= 16 * p && n <= 17 * p + 4, 1'b1)
        end
        rd(ADCSQ_OFS_CTRL_A);
        `CHK(rv, {2'b00, 3'b000, lo})
        `CHK({pd, ref_o, chan_sel_o}, {1'b0, b[3], b[7], lo})
        rd(ADCSQ_OFS_IRQ_CTRL);
        `CHK(rv[2], 1'b1)
        rd(ADCSQ_OFS_RES_LO);
        hi = rv;
        rd(ADCSQ_OFS_RES_HI);
        `CHK({rv, hi}, {4'h0, exp_q[0]})
        rd(ADCSQ_OFS_IRQ_STAT);
        `CHK(rv[0], 1'b1)
    endtask

    task automatic irq_is(input logic e);
        repeat (2) @(posedge clock_i);
        #1 `CHK(irq_o, e)
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Cut a hang well past the longest expected run
    initial begin
        #(60000 * 10);
        n_errors++;
        $display("watchdog expired");
        report_and_stop;
    end

    // Main sequence
    initial begin
        repeat (8) @(posedge clock_i);
        arst_n_i <= 1'b1;
        // Reset values, unmapped reads as zero
        for (int a = 0; a < 16; a++) begin
            rd(a[3:0]);
            `CHK(rv, (a == 0) ? ADCSQ_RST_CTRL_A : 8'h00)
        end
        wr(4'h9, 8'hFF);
        rd(4'h9);
        `CHK(rv, 8'h00)
        b = 8'($random(seed));
        wr(ADCSQ_OFS_PIN_EN, b);
        rd(ADCSQ_OFS_PIN_EN);
        `CHK({rv, pen, pfo, pdo, ppo}, {5{b}})
        wr(ADCSQ_OFS_IRQ_CTRL, 8'h03);
        for (int s = 0; s < 8; s++) begin
            conv(s, 1'b1);
            wr(ADCSQ_OFS_IRQ_CTRL, 8'h03);
            irq_is(1'b0);
        end
        wr(ADCSQ_OFS_IRQ_CTRL, 8'h02);
        conv(2, 1'b0);
        irq_is(1'b0);
        wr(ADCSQ_OFS_IRQ_CTRL, 8'h07);
        irq_is(1'b1);
        wr(ADCSQ_OFS_IRQ_CTRL, 8'h03);
        irq_is(1'b0);
        // Masked status path, cleared by the status read
        wr(ADCSQ_OFS_IRQ_CTRL, 8'h00);
        wr(ADCSQ_OFS_IRQ_MASK, 8'h01);
        conv(1, 1'b1);
        irq_is(1'b0);
        wr(ADCSQ_OFS_CTRL_A, 8'hA0);
        wr(ADCSQ_OFS_CTRL_A, 8'h20);
        repeat (40) @(posedge clock_i);
        rd(ADCSQ_OFS_CTRL_A);
        `CHK({rv, pd, afe, irq_o}, {8'h20, 3'b100})
        report_and_stop;
    end
endmodule
`default_nettype wire
